/* File: shared/wake_pkg.sv */
// Shared constants and types for the stop-mode wake source controller.
// Assumes a 32-bit register port driven from the ref_clk domain.
`default_nettype none

package wake_pkg;

    typedef logic [31:0] word_t;

    // Register byte addresses
    localparam word_t ADDR_EN_INT   = 32'h4000_4020;
    localparam word_t ADDR_RAW_INT  = 32'h4000_4024;
    localparam word_t ADDR_MSK_INT  = 32'h4000_4028;
    localparam word_t ADDR_POL_INT  = 32'h4000_402C;
    localparam word_t ADDR_EN_PIN   = 32'h4000_4030;
    localparam word_t ADDR_RAW_PIN  = 32'h4000_4034;
    localparam word_t ADDR_MSK_PIN  = 32'h4000_4038;
    localparam word_t ADDR_POL_PIN  = 32'h4000_403C;
    localparam word_t ADDR_IRQ_STAT = 32'h4000_4040;
    localparam word_t ADDR_IRQ_MASK = 32'h4000_4044;

    // Internal source bit positions
    localparam int BIT_ADC        = 31;
    localparam int BIT_HOST_CLK   = 26;
    localparam int BIT_MS_TIMER   = 25;
    localparam int BIT_RTC        = 24;
    localparam int BIT_USB_LO     = 19;
    localparam int BIT_KEYSCAN    = 16;
    localparam int BIT_GPIO_HI    = 5;

    // External pin bit positions
    localparam int BIT_U7_RECV    = 31;
    localparam int BIT_U7_CTS     = 30;
    localparam int BIT_U6_IR_RECV = 28;

    // Implemented bits: adc, usb 26 and 23..19, ms timer 25, rtc 24, keyscan, gpio 5..0
    localparam word_t INT_IMPL =
        (32'h1 << BIT_ADC) | (32'h1 << BIT_HOST_CLK) |
        (32'h1 << BIT_MS_TIMER) | (32'h1 << BIT_RTC) |
        (32'h0000_001F << BIT_USB_LO) | (32'h1 << BIT_KEYSCAN) |
        ((32'h1 << (BIT_GPIO_HI + 1)) - 32'h1);
    localparam word_t PIN_IMPL =
        (32'h1 << BIT_U7_RECV) | (32'h1 << BIT_U7_CTS) |
        (32'h1 << BIT_U6_IR_RECV);

    // Status bits 2:0 are reserved and read back as zero
    localparam word_t RAW_RD_MASK = 32'hFFFF_FFF8;

    localparam word_t EN_RST      = 32'h0000_0000;
    localparam word_t POL_RST     = 32'h0000_0000;
    localparam word_t RAW_RST     = 32'h0000_0000;

    // Interrupt status fields
    localparam int EV_W       = 3;
    localparam int EV_INT_CAP = 0;
    localparam int EV_PIN_CAP = 1;
    localparam int EV_WAKE    = 2;
    localparam logic [EV_W-1:0] IRQ_MASK_RST = 3'h0;

    typedef struct packed {
        word_t addr;
        word_t wdata;
        logic  wr;
        logic  rd;
    } bus_req_s;

endpackage

`default_nettype wire

/* File: rtl/src_capture.sv */
// Synchronises a vector of wake sources and captures the chosen edge.
// Assumes sources may change at any time relative to ref_clk.
`timescale 1ns/10ps
`default_nettype none

module src_capture #(
    parameter int          W    = 32,
    parameter logic [31:0] IMPL = 32'hFFFF_FFFF
) (
    input  wire logic         ref_clk,  // System clock
    input  wire logic         rst_n,    // Synchronous reset, active low
    input  wire logic [W-1:0] src,      // Raw asynchronous sources
    input  wire logic [W-1:0] pol,      // 1 rising, 0 falling edge
    input  wire logic [W-1:0] clr,      // Write-one-to-clear strobes
    output logic      [W-1:0] raw,      // Captured state
    output logic              new_cap   // Pulse on any fresh capture
);
    logic [W-1:0] sync1_reg, sync2_reg, prev_reg, raw_reg;
    logic         new_reg;
    wire  [W-1:0] rise_w  = sync2_reg & ~prev_reg;
    wire  [W-1:0] fall_w  = ~sync2_reg & prev_reg;
    wire  [W-1:0] edge_w  = ((pol & rise_w) | (~pol & fall_w)) & IMPL[W-1:0];
    // A new edge beats a clear in the same cycle
    wire  [W-1:0] raw_next = (raw_reg & ~clr) | edge_w;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            prev_reg  <= '0;
            raw_reg   <= '0;
            new_reg   <= 1'b0;
        end else begin
            sync1_reg <= src;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
            raw_reg   <= raw_next;
            new_reg   <= |edge_w;
        end
    end

    assign raw     = raw_reg;
    assign new_cap = new_reg;

    edge_sets_bit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (|edge_w) |=> ((raw_reg & $past(edge_w)) == $past(edge_w)))
        else $error("selected edge not captured");
    clear_drops_bit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (|(clr & ~edge_w & raw_reg)) |=>
        ((raw_reg & $past(clr & ~edge_w)) == '0))
        else $error("write-one clear did not clear bit");
endmodule // src_capture

`default_nettype wire

/* File: rtl/event_irq.sv */
// Sticky event status cleared by read, masked onto one level interrupt.
// Assumes event pulses and read strobe come from the ref_clk domain.
`timescale 1ns/10ps
`default_nettype none

module event_irq #(
    parameter int W = 3
) (
    input  wire logic         ref_clk,  // System clock
    input  wire logic         rst_n,    // Synchronous reset, active low
    input  wire logic [W-1:0] ev,       // Event pulses
    input  wire logic         rd_clr,   // Status read, clears all bits
    input  wire logic [W-1:0] mask,     // 1 lets the bit reach irq
    output logic      [W-1:0] stat,     // Sticky status
    output logic              irq       // Level interrupt
);
    logic [W-1:0] stat_reg;
    logic         irq_reg;
    // Events landing in the clearing read stay set
    wire  [W-1:0] stat_next = (rd_clr ? '0 : stat_reg) | ev;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            stat_reg <= '0;
            irq_reg  <= 1'b0;
        end else begin
            stat_reg <= stat_next;
            irq_reg  <= |(stat_next & mask);
        end
    end

    assign stat = stat_reg;
    assign irq  = irq_reg;

    irq_follows_stat_a: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        $past(rst_n) && $stable(mask) |-> (irq_reg == |(stat_reg & mask)))
        else $error("irq disagrees with masked status");
endmodule // event_irq

`default_nettype wire

/* File: rtl/wake_ctrl.sv */
// Stop-mode wake source controller: enables, polarity, raw and masked
// status for internal sources and pins, wake request and interrupt.
// Assumes a single-cycle strobe register port on ref_clk.
//
// Summary of operation
// - One enable bit per internal source; only enabled sources may wake.
// - Separate pin enable register: bit 31, 30, 28 for uart pins.
// - Enable bit 0 disables a source, 1 enables it.
// - Bit 16 is the keyboard scanner, bits 5..0 the gpio inputs.
// - Bit 31 converter, 24 clock, 25 ms timer, 26 and 23..19 usb.
// - Raw status reads 1 for a captured source, before masking; here gpio bits 2..0 read 0 even when captured.
// - Writing 1 to a raw status bit clears it, 0 leaves it.
// - Raw bits 31..3 match enable bits; implemented bits reset to 0.
// - Masked status equals raw status and enable together.
// - Polarity 1 captures on rising edge, 0 on falling edge.
//
// The strobed register port was decided locally.
`timescale 1ns/10ps
`default_nettype none

module wake_ctrl #(
    parameter int W = 32
) (
    input  wire logic             ref_clk,  // 40 MHz system clock
    input  wire logic             rst_n,    // Synchronous reset, low
    input  wire wake_pkg::bus_req_s bus_req,  // Register request
    output logic          [W-1:0] rd_data,  // Read data, next cycle
    input  wire logic     [W-1:0] int_src,  // Internal interrupt lines
    input  wire logic     [W-1:0] pin_src,  // External wake pins
    output logic                  wake_req, // Leave stop mode
    output logic                  irq       // Level interrupt
);

    function automatic logic hit(input wake_pkg::word_t a,
                                 input wake_pkg::word_t t,
                                 input logic strobe);
        hit = strobe && (a == t);
    endfunction

    // Software-visible state
    logic [W-1:0]             en_int_reg;
    logic [W-1:0]             en_pin_reg;
    logic [W-1:0]             pol_int_reg;
    logic [W-1:0]             pol_pin_reg;
    logic [wake_pkg::EV_W-1:0] irq_mask_reg;
    logic [W-1:0]             rd_data_reg;
    logic                     wake_req_reg;

    // Capture outputs
    logic [W-1:0]             raw_int;
    logic [W-1:0]             raw_pin;
    logic                     new_int;
    logic                     new_pin;
    logic [wake_pkg::EV_W-1:0] irq_stat;

    // Write decode
    wire wr_en_int   = hit(bus_req.addr, wake_pkg::ADDR_EN_INT,   bus_req.wr);
    wire wr_en_pin   = hit(bus_req.addr, wake_pkg::ADDR_EN_PIN,   bus_req.wr);
    wire wr_pol_int  = hit(bus_req.addr, wake_pkg::ADDR_POL_INT,  bus_req.wr);
    wire wr_pol_pin  = hit(bus_req.addr, wake_pkg::ADDR_POL_PIN,  bus_req.wr);
    wire wr_raw_int  = hit(bus_req.addr, wake_pkg::ADDR_RAW_INT,  bus_req.wr);
    wire wr_raw_pin  = hit(bus_req.addr, wake_pkg::ADDR_RAW_PIN,  bus_req.wr);
    wire wr_irq_mask = hit(bus_req.addr, wake_pkg::ADDR_IRQ_MASK, bus_req.wr);

    // Read decode
    wire rd_en_int   = hit(bus_req.addr, wake_pkg::ADDR_EN_INT,   bus_req.rd);
    wire rd_en_pin   = hit(bus_req.addr, wake_pkg::ADDR_EN_PIN,   bus_req.rd);
    wire rd_pol_int  = hit(bus_req.addr, wake_pkg::ADDR_POL_INT,  bus_req.rd);
    wire rd_pol_pin  = hit(bus_req.addr, wake_pkg::ADDR_POL_PIN,  bus_req.rd);
    wire rd_raw_int  = hit(bus_req.addr, wake_pkg::ADDR_RAW_INT,  bus_req.rd);
    wire rd_raw_pin  = hit(bus_req.addr, wake_pkg::ADDR_RAW_PIN,  bus_req.rd);
    wire rd_msk_int  = hit(bus_req.addr, wake_pkg::ADDR_MSK_INT,  bus_req.rd);
    wire rd_msk_pin  = hit(bus_req.addr, wake_pkg::ADDR_MSK_PIN,  bus_req.rd);
    wire rd_irq_stat = hit(bus_req.addr, wake_pkg::ADDR_IRQ_STAT, bus_req.rd);
    wire rd_irq_mask = hit(bus_req.addr, wake_pkg::ADDR_IRQ_MASK, bus_req.rd);

    // Only implemented bits hold state, so reserved bits never latch ones
    wire [W-1:0] int_impl = wake_pkg::INT_IMPL[W-1:0];
    wire [W-1:0] pin_impl = wake_pkg::PIN_IMPL[W-1:0];
    wire [W-1:0] wdata    = bus_req.wdata[W-1:0];

    wire [W-1:0] en_int_next  = wr_en_int  ? (wdata & int_impl)
                                           : en_int_reg;
    wire [W-1:0] en_pin_next  = wr_en_pin  ? (wdata & pin_impl)
                                           : en_pin_reg;
    wire [W-1:0] pol_int_next = wr_pol_int ? (wdata & int_impl)
                                           : pol_int_reg;
    wire [W-1:0] pol_pin_next = wr_pol_pin ? (wdata & pin_impl)
                                           : pol_pin_reg;
    wire [wake_pkg::EV_W-1:0] irq_mask_next =
        wr_irq_mask ? wdata[wake_pkg::EV_W-1:0] : irq_mask_reg;

    // W1C strobes reach the capture stage only on a raw status write
    wire [W-1:0] clr_int = wr_raw_int ? wdata : '0;
    wire [W-1:0] clr_pin = wr_raw_pin ? wdata : '0;

    // Masked views
    wire [W-1:0] msk_int = raw_int & en_int_reg;
    wire [W-1:0] msk_pin = raw_pin & en_pin_reg;

    // Only sources both captured and enabled may wake the chip
    wire wake_next = (|msk_int) | (|msk_pin);

    // Status bits 2:0 hide behind the reserved field on readback
    wire [W-1:0] raw_rd_mask = wake_pkg::RAW_RD_MASK[W-1:0];

    // Read mux; unmapped addresses return zero
    wire [W-1:0] rd_mux =
        rd_en_int   ? en_int_reg                 :
        rd_en_pin   ? en_pin_reg                 :
        rd_pol_int  ? pol_int_reg                :
        rd_pol_pin  ? pol_pin_reg                :
        rd_raw_int  ? (raw_int & raw_rd_mask)    :
        rd_raw_pin  ? (raw_pin & raw_rd_mask)    :
        rd_msk_int  ? (msk_int & raw_rd_mask)    :
        rd_msk_pin  ? (msk_pin & raw_rd_mask)    :
        rd_irq_stat ? {{(W-wake_pkg::EV_W){1'b0}}, irq_stat}     :
        rd_irq_mask ? {{(W-wake_pkg::EV_W){1'b0}}, irq_mask_reg} :
                      '0;

    // Events for the interrupt status
    logic [wake_pkg::EV_W-1:0] ev;
    assign ev[wake_pkg::EV_INT_CAP] = new_int;
    assign ev[wake_pkg::EV_PIN_CAP] = new_pin;
    assign ev[wake_pkg::EV_WAKE]    = wake_next & ~wake_req_reg;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            en_int_reg  <= wake_pkg::EN_RST[W-1:0];
            en_pin_reg  <= wake_pkg::EN_RST[W-1:0];
            pol_int_reg <= wake_pkg::POL_RST[W-1:0];
            pol_pin_reg <= wake_pkg::POL_RST[W-1:0];
        end else begin
            en_int_reg  <= en_int_next;
            en_pin_reg  <= en_pin_next;
            pol_int_reg <= pol_int_next;
            pol_pin_reg <= pol_pin_next;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            irq_mask_reg <= wake_pkg::IRQ_MASK_RST;
            rd_data_reg  <= '0;
            wake_req_reg <= 1'b0;
        end else begin
            irq_mask_reg <= irq_mask_next;
            rd_data_reg  <= rd_mux;
            wake_req_reg <= wake_next;
        end
    end

    src_capture #(
        .W    (W),
        .IMPL (wake_pkg::INT_IMPL)
    ) u_cap_int (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .src     (int_src),
        .pol     (pol_int_reg),
        .clr     (clr_int),
        .raw     (raw_int),
        .new_cap (new_int)
    );

    src_capture #(
        .W    (W),
        .IMPL (wake_pkg::PIN_IMPL)
    ) u_cap_pin (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .src     (pin_src),
        .pol     (pol_pin_reg),
        .clr     (clr_pin),
        .raw     (raw_pin),
        .new_cap (new_pin)
    );

    event_irq #(
        .W (wake_pkg::EV_W)
    ) u_irq (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .ev      (ev),
        .rd_clr  (rd_irq_stat),
        .mask    (irq_mask_reg),
        .stat    (irq_stat),
        .irq     (irq)
    );

    assign rd_data  = rd_data_reg;
    assign wake_req = wake_req_reg;

    // Checks

    enable_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_en_int |=> (en_int_reg == ($past(wdata) & int_impl)))
        else $error("internal enable write not stored");

    pin_enable_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_en_pin |=> (en_pin_reg == ($past(wdata) & pin_impl)))
        else $error("pin enable write not stored");

    enable_coding_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (wr_en_int && !wdata[wake_pkg::BIT_KEYSCAN])
        |=> !en_int_reg[wake_pkg::BIT_KEYSCAN])
        else $error("zero did not disable the source");

    source_map_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (wr_en_int && wdata[wake_pkg::BIT_KEYSCAN] && wdata[0])
        |=> (en_int_reg[wake_pkg::BIT_KEYSCAN] && en_int_reg[0]))
        else $error("keyscan or gpio enable missing");

    upper_map_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (wr_en_int && wdata[wake_pkg::BIT_ADC] && wdata[wake_pkg::BIT_RTC])
        |=> (en_int_reg[wake_pkg::BIT_ADC] && en_int_reg[wake_pkg::BIT_RTC]))
        else $error("converter or clock enable missing");

    raw_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rd_raw_int |=> (rd_data_reg == ($past(raw_int) & raw_rd_mask)))
        else $error("raw status read mismatch");

    masked_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rd_msk_int |=>
        (rd_data_reg == ($past(raw_int & en_int_reg) & raw_rd_mask)))
        else $error("masked status read mismatch");

    reset_clear_a: assert property (@(posedge ref_clk)
        !rst_n |=> (en_int_reg == '0 && en_pin_reg == '0 && raw_int == '0))
        else $error("enable or status not zero after reset");

    wake_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ##1 (wake_req_reg == $past(|(raw_int & en_int_reg)
                                  | |(raw_pin & en_pin_reg))))
        else $error("wake request does not follow enabled captures");

    unmapped_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (bus_req.rd && rd_mux == '0 && !rd_irq_stat) |=> (rd_data_reg == '0))
        else $error("read data not zero for empty read");

endmodule // wake_ctrl

`default_nettype wire

/* File: verif/src_model.sv */
// Far-side model: internal interrupt lines and wake pins as seen by wake_ctrl.
// Assumes the bench commands target levels on ref_clk; they arrive DLY later.
`timescale 1ns/10ps
`default_nettype none

module src_model #(
    parameter int DLY = 1
) (
    input  wire logic        ref_clk,   // System clock
    input  wire logic [31:0] want_int,  // Commanded internal line levels
    input  wire logic [31:0] want_pin,  // Commanded pin levels
    output logic      [31:0] int_src,   // Internal interrupt lines
    output logic      [31:0] pin_src    // External wake pins
);
    // Levels only move after a clock edge, so a slow peripheral is a longer
    // pipe; they never glitch, which keeps capture timing predictable
    logic [63:0] pipe [DLY];

    always_ff @(posedge ref_clk) begin
        pipe[0] <= {want_int, want_pin};
        for (int i = 1; i < DLY; i++) begin
            pipe[i] <= pipe[i-1];
        end
    end

    assign {int_src, pin_src} = pipe[DLY-1];
endmodule // src_model

`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking bench for wake_ctrl: register map, capture, wake and irq.
// Assumes the register port answers reads one cycle after the strobe.
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin fails++; \
    $display("[FAIL] %0t got %h exp %h", $time, got, exp); end end

module tb_top;
    typedef struct packed {
        wake_pkg::word_t addr;
        wake_pkg::word_t wdata;
        wake_pkg::word_t exp;
    } row_s;

    logic               ref_clk;
    logic               rst_n;
    wake_pkg::bus_req_s bus_req;
    logic        [31:0] rd_data;
    logic        [31:0] int_src;
    logic        [31:0] pin_src;
    logic        [31:0] want_int;
    logic        [31:0] want_pin;
    logic               wake_req;
    logic               irq;
    wake_pkg::word_t    d;
    row_s               rows [11];
    int                 fails;
    int                 compares;
    int                 cycles;

    wake_ctrl #(.W(32)) uut (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .bus_req  (bus_req),
        .rd_data  (rd_data),
        .int_src  (int_src),
        .pin_src  (pin_src),
        .wake_req (wake_req),
        .irq      (irq)
    );

    src_model #(.DLY(2)) far (
        .ref_clk  (ref_clk),
        .want_int (want_int),
        .want_pin (want_pin),
        .int_src  (int_src),
        .pin_src  (pin_src)
    );

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic wrap_up();
        if (fails == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Hang guard: the whole sequence needs well under 1000 cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            $display("[FAIL] %0t run did not finish", $time);
            wrap_up();
        end
    end

    task automatic wr_reg(input wake_pkg::word_t a, input wake_pkg::word_t v);
        @(posedge ref_clk);
        bus_req.addr  <= a;
        bus_req.wdata <= v;
        bus_req.wr    <= 1'b1;
        @(posedge ref_clk);
        bus_req.wr    <= 1'b0;
    endtask

    task automatic rd_reg(input wake_pkg::word_t a, output wake_pkg::word_t v);
        @(posedge ref_clk);
        bus_req.addr <= a;
        bus_req.rd   <= 1'b1;
        @(posedge ref_clk);
        bus_req.rd   <= 1'b0;
        #1;
        v = rd_data;
    endtask

    task automatic settle();
        repeat (10) @(posedge ref_clk);
        #1;
    endtask

    initial begin
        fails    = 0;
        compares = 0;
        cycles   = 0;
        rst_n    = 1'b0;
        bus_req  = '0;
        want_int = 32'h0000_0000;
        want_pin = 32'hFFFF_FFFF;
        // Software keeps reserved enable bits at zero
        rows[0] = {wake_pkg::ADDR_EN_INT, 32'h87F9_003F, 32'h87F9_003F};
        rows[1] = {wake_pkg::ADDR_EN_INT, 32'h0001_0000, 32'h0001_0000};
        rows[2] = {wake_pkg::ADDR_EN_INT, 32'h0000_003F, 32'h0000_003F};
        rows[3] = {wake_pkg::ADDR_EN_INT, 32'h8300_0000, 32'h8300_0000};
        rows[4] = {wake_pkg::ADDR_EN_PIN, 32'hD000_0000, 32'hD000_0000};
        rows[5] = {wake_pkg::ADDR_EN_PIN, 32'h0000_0000, 32'h0000_0000};
        rows[6] = {wake_pkg::ADDR_POL_INT, 32'h87F9_003F, 32'h87F9_003F};
        rows[7] = {wake_pkg::ADDR_POL_PIN, 32'hD000_0000, 32'hD000_0000};
        // Pin polarity back to falling for the pin capture below
        rows[8] = {wake_pkg::ADDR_POL_PIN, 32'h0000_0000, 32'h0000_0000};
        rows[9] = {wake_pkg::ADDR_IRQ_MASK, 32'h0000_0007, 32'h0000_0007};
        rows[10] = {32'h4000_4050, 32'hFFFF_FFFF, 32'h0000_0000};
        repeat (4) @(posedge ref_clk);
        #1;
        `CHK({wake_req, irq}, 2'h0)
        rst_n <= 1'b1;
        rd_reg(wake_pkg::ADDR_EN_INT, d);
        `CHK(d, 32'h0000_0000)
        rd_reg(wake_pkg::ADDR_RAW_INT, d);
        `CHK(d, 32'h0000_0000)
        rd_reg(wake_pkg::ADDR_EN_PIN, d);
        `CHK(d, 32'h0000_0000)
        foreach (rows[i]) begin
            wr_reg(rows[i].addr, rows[i].wdata);
            rd_reg(rows[i].addr, d);
            `CHK(d, rows[i].exp)
        end
        // Rising capture on keyscan, converter and gpio 0; only keyscan enabled
        wr_reg(wake_pkg::ADDR_POL_INT, 32'h87F9_003F);
        wr_reg(wake_pkg::ADDR_EN_INT, 32'h0001_0000);
        wr_reg(wake_pkg::ADDR_IRQ_MASK, 32'h0000_0007);
        @(posedge ref_clk);
        want_int <= 32'h8001_0001;
        settle();
        `CHK({wake_req, irq}, 2'h3)
        rd_reg(wake_pkg::ADDR_RAW_INT, d);
        `CHK(d, 32'h8001_0000)
        rd_reg(wake_pkg::ADDR_MSK_INT, d);
        `CHK(d, 32'h0001_0000)
        rd_reg(wake_pkg::ADDR_IRQ_STAT, d);
        `CHK(d, 32'h0000_0005)
        rd_reg(wake_pkg::ADDR_IRQ_STAT, d);
        `CHK(d, 32'h0000_0000)
        `CHK(irq, 1'b0)
        // Clearing keyscan alone must leave the converter capture standing
        wr_reg(wake_pkg::ADDR_RAW_INT, 32'h0001_0000);
        rd_reg(wake_pkg::ADDR_RAW_INT, d);
        `CHK(d, 32'h8000_0000)
        settle();
        `CHK(wake_req, 1'b0)
        // Falling-edge capture on the infrared receive pin
        wr_reg(wake_pkg::ADDR_EN_PIN, 32'h1000_0000);
        @(posedge ref_clk);
        want_pin <= 32'hEFFF_FFFF;
        settle();
        `CHK(wake_req, 1'b1)
        rd_reg(wake_pkg::ADDR_RAW_PIN, d);
        `CHK(d, 32'h1000_0000)
        rd_reg(wake_pkg::ADDR_MSK_PIN, d);
        `CHK(d, 32'h1000_0000)
        rd_reg(wake_pkg::ADDR_IRQ_STAT, d);
        `CHK(d, 32'h0000_0006)
        wr_reg(wake_pkg::ADDR_RAW_PIN, 32'h0000_0000);
        rd_reg(wake_pkg::ADDR_RAW_PIN, d);
        `CHK(d, 32'h1000_0000)
        wr_reg(wake_pkg::ADDR_RAW_PIN, 32'h1000_0000);
        settle();
        `CHK(wake_req, 1'b0)
        // Reset in mid-run returns enables and captures to zero
        wr_reg(wake_pkg::ADDR_EN_PIN, 32'hD000_0000);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd_reg(wake_pkg::ADDR_EN_PIN, d);
        `CHK(d, 32'h0000_0000)
        rd_reg(wake_pkg::ADDR_RAW_INT, d);
        `CHK(d, 32'h0000_0000)
        wrap_up();
    end
endmodule // tb_top

`default_nettype wire
